// file: rtl/adcwm_monitor.sv
// Converter result window monitor: trigger overflow flag, one shared window
// comparator over results written to result memory or FIFO, sticky flags, irq.
// Assumes the sequencer signals run on mclk and AXI4-Lite master on mclk.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "adcwm_defines.svh"

module adcwm_monitor
    import adcwm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter sequencer
    input wire logic conv_trigger,
    input wire logic conv_busy,
    input wire logic result_write,
    input wire logic [`ADCWM_DW-1:0] result_data,
    input wire logic [`ADCWM_CHW-1:0] result_channel,
    // Configuration towards the converter and interrupt
    output logic result_data_format,
    output logic [1:0] conversion_resolution,
    output logic irq
);

    // ==========================================================
    // Reset synchroniser, kept apart so its flops reset to a constant
    logic rst_q1_reg;
    logic rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_q1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_q1_reg <= 1'b1;
            rst_sync_n <= rst_q1_reg;
        end
    end

    // ==========================================================
    // Byte-lane merge for register writes
    function automatic logic [31:0] adcwm_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : adcwm_merge

    // ==========================================================
    // Shared window comparator
    adcwm_state_s s_reg;
    adcwm_state_s s_next;
    logic cmp_hit;
    logic cls_below;
    logic cls_above;
    logic cls_inside;
    logic wr_fire;
    logic [`ADCWM_NFLAG-1:0] clr_mask;
    logic [`ADCWM_NFLAG-1:0] set_mask;

    // Signed format compares as two's complement, otherwise unsigned
    always_comb
    begin
        cmp_hit = result_write && s_reg.chan_en[result_channel];
        if (s_reg.fmt_signed)
        begin
            cls_below = $signed(result_data) < $signed(s_reg.wlow);
            cls_above = $signed(result_data) > $signed(s_reg.whigh);
        end
        else
        begin
            cls_below = result_data < s_reg.wlow;
            cls_above = result_data > s_reg.whigh;
        end
        // Low wins if thresholds are crossed, so one class only
        cls_above = cls_above && !cls_below;
        cls_inside = !cls_below && !cls_above;
    end

    // Events and clears of the sticky flags
    always_comb
    begin
        wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
        clr_mask = '0;
        if (wr_fire && s_reg.aw_addr == `ADCWM_OFS_CLEAR)
            clr_mask = s_reg.w_data[`ADCWM_NFLAG-1:0];
        set_mask = '0;
        set_mask[`ADCWM_BIT_TOV] = conv_trigger && conv_busy;
        set_mask[`ADCWM_BIT_LOW] = cmp_hit && cls_below;
        set_mask[`ADCWM_BIT_HIGH] = cmp_hit && cls_above;
        set_mask[`ADCWM_BIT_IN] = cmp_hit && cls_inside;
    end

    // ==========================================================
    // Next-state logic: bus slave, registers, flags
    always_comb
    begin
        s_next = s_reg;
        // Address and data are taken in either order and held
        if (s_axi_awvalid && s_reg.awready)
        begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready)
        begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready)
            s_next.bvalid = 1'b0;
        if (wr_fire)
        begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `ADCWM_RESP_OKAY;
            unique case (s_reg.aw_addr)
                `ADCWM_OFS_CTRL:
                begin
                    // Thresholds are deliberately not touched here
                    if (s_reg.w_strb[0])
                    begin
                        s_next.fmt_signed = s_reg.w_data[`ADCWM_BIT_FMT];
                        s_next.resolution =
                            s_reg.w_data[`ADCWM_RES_MSB:`ADCWM_RES_LSB];
                    end
                end
                `ADCWM_OFS_CHEN:
                    s_next.chan_en = adcwm_merge(s_reg.chan_en, s_reg.w_data,
                                                 s_reg.w_strb);
                `ADCWM_OFS_WLOW:
                    s_next.wlow = 16'(adcwm_merge({`ADCWM_ZERO16, s_reg.wlow},
                                                  s_reg.w_data, s_reg.w_strb));
                `ADCWM_OFS_WHIGH:
                    s_next.whigh = 16'(adcwm_merge({`ADCWM_ZERO16, s_reg.whigh},
                                                   s_reg.w_data, s_reg.w_strb));
                `ADCWM_OFS_IRQEN:
                    if (s_reg.w_strb[0])
                        s_next.irq_en = s_reg.w_data[`ADCWM_NFLAG-1:0];
                `ADCWM_OFS_CLEAR, `ADCWM_OFS_STATUS, `ADCWM_OFS_LAST: ;
                default:
                    s_next.bresp = `ADCWM_RESP_SLVERR;
            endcase
        end
        // Read: one outstanding, answered the cycle after the address
        if (s_reg.rvalid && s_axi_rready)
            s_next.rvalid = 1'b0;
        if (s_axi_arvalid && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `ADCWM_RESP_OKAY;
            s_next.rdata = `ADCWM_ZERO32;
            unique case (s_axi_araddr)
                `ADCWM_OFS_CTRL:
                begin
                    s_next.rdata[`ADCWM_BIT_FMT] = s_reg.fmt_signed;
                    s_next.rdata[`ADCWM_RES_MSB:`ADCWM_RES_LSB] = s_reg.resolution;
                end
                `ADCWM_OFS_CHEN: s_next.rdata = s_reg.chan_en;
                `ADCWM_OFS_WLOW: s_next.rdata[`ADCWM_DW-1:0] = s_reg.wlow;
                `ADCWM_OFS_WHIGH: s_next.rdata[`ADCWM_DW-1:0] = s_reg.whigh;
                `ADCWM_OFS_STATUS: s_next.rdata[`ADCWM_NFLAG-1:0] = s_reg.status;
                `ADCWM_OFS_IRQEN: s_next.rdata[`ADCWM_NFLAG-1:0] = s_reg.irq_en;
                `ADCWM_OFS_LAST: s_next.rdata[`ADCWM_DW-1:0] = s_reg.last_result;
                `ADCWM_OFS_CLEAR: ;
                default: s_next.rresp = `ADCWM_RESP_SLVERR;
            endcase
        end
        // Last compared result for software inspection
        if (cmp_hit)
            s_next.last_result = result_data;
        // Set wins over a clear in the same cycle
        s_next.status = (s_reg.status & ~clr_mask) | set_mask;
        s_next.irq = |(s_next.status & s_next.irq_en);
        // Ready flags registered so outputs come straight from flops
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
        s_next.rst_q1 = 1'b0;
        s_next.rst_q2 = 1'b0;
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s_reg <= '0;
            s_reg.whigh <= `ADCWM_HIGH_RST;
        end
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign result_data_format = s_reg.fmt_signed;
    assign conversion_resolution = s_reg.resolution;
    assign irq = s_reg.irq;

    // ==========================================================
    // Assertions
    a_trig_overflow: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        conv_trigger && conv_busy |=> s_reg.status[`ADCWM_BIT_TOV])
        else $error("trigger while busy did not set overflow flag");

    a_irq_enabled: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        s_reg.irq == |(s_reg.status & s_reg.irq_en))
        else $error("interrupt does not match enabled flags");

    a_one_class: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        $onehot({cls_below, cls_above, cls_inside}))
        else $error("comparator class is not unique");

    a_below_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        cmp_hit && cls_below |=> s_reg.status[`ADCWM_BIT_LOW]
            && s_reg.last_result == $past(result_data))
        else $error("below result did not set below flag");

    a_above_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        cmp_hit && !s_reg.fmt_signed && result_data > s_reg.whigh
            && s_reg.wlow <= s_reg.whigh |=> s_reg.status[`ADCWM_BIT_HIGH])
        else $error("above result did not set above flag");

    a_inside_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        cmp_hit && !s_reg.fmt_signed && result_data == s_reg.wlow
            && s_reg.wlow <= s_reg.whigh
            |=> s_reg.status[`ADCWM_BIT_IN])
        else $error("result equal to low threshold not inside");

    a_no_compare: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !(result_write && s_reg.chan_en[result_channel])
            |=> (s_reg.status[3:1] & ~$past(s_reg.status[3:1])) == 3'h0)
        else $error("window flag set without enabled result write");

    a_thr_kept: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        wr_fire && s_reg.aw_addr == `ADCWM_OFS_CTRL
            |=> $stable(s_reg.wlow) && $stable(s_reg.whigh))
        else $error("thresholds changed by format write");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        s_reg.status[`ADCWM_BIT_TOV] && !clr_mask[`ADCWM_BIT_TOV]
            |=> s_reg.status[`ADCWM_BIT_TOV])
        else $error("overflow flag dropped without clear");

    // A clear without a competing event must really drop the flag
    a_clear_drops: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        clr_mask[`ADCWM_BIT_TOV] && !set_mask[`ADCWM_BIT_TOV]
            |=> !s_reg.status[`ADCWM_BIT_TOV])
        else $error("overflow flag not dropped by clear write");

    // Results that are not compared leave the last result alone
    a_last_kept: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !cmp_hit |=> $stable(s_reg.last_result))
        else $error("last result changed without compared write");

endmodule : adcwm_monitor

// file: rtl/adcwm_defines.svh
// Constants of the converter result window monitor: register map, fields, codes.
// Assumes inclusion by bare name from the package and the monitor module.
`ifndef ADCWM_DEFINES_SVH
`define ADCWM_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ADCWM_OFS_CTRL 8'h00
`define ADCWM_OFS_CHEN 8'h04
`define ADCWM_OFS_WLOW 8'h08
`define ADCWM_OFS_WHIGH 8'h0C
`define ADCWM_OFS_STATUS 8'h10
`define ADCWM_OFS_IRQEN 8'h14
`define ADCWM_OFS_CLEAR 8'h18
`define ADCWM_OFS_LAST 8'h1C

// ==========================================================
// Field positions of status, enable and clear
`define ADCWM_BIT_TOV 0
`define ADCWM_BIT_LOW 1
`define ADCWM_BIT_HIGH 2
`define ADCWM_BIT_IN 3
// Control register fields
`define ADCWM_BIT_FMT 0
`define ADCWM_RES_LSB 1
`define ADCWM_RES_MSB 2

// ==========================================================
// Widths, reset values and bus answers
`define ADCWM_NFLAG 4
`define ADCWM_DW 16
`define ADCWM_CHW 5
`define ADCWM_ZERO32 32'h0000_0000
`define ADCWM_ZERO16 16'h0000
`define ADCWM_HIGH_RST 16'hFFFF
`define ADCWM_RESP_OKAY 2'h0
`define ADCWM_RESP_SLVERR 2'h2

`endif

// file: rtl/adcwm_pkg.sv
// Types of the converter result window monitor.
// Assumes the constants header is on the include path.
`include "adcwm_defines.svh"

package adcwm_pkg;

    // State of the monitor apart from the reset synchroniser, registered in one process
    typedef struct packed {
        logic rst_q1;
        logic rst_q2;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic fmt_signed;
        logic [1:0] resolution;
        logic [31:0] chan_en;
        logic [`ADCWM_DW-1:0] wlow;
        logic [`ADCWM_DW-1:0] whigh;
        logic [`ADCWM_NFLAG-1:0] status;
        logic [`ADCWM_NFLAG-1:0] irq_en;
        logic [`ADCWM_DW-1:0] last_result;
        logic irq;
    } adcwm_state_s;

endpackage : adcwm_pkg

// file: testbench/adcwm_seq_model.sv
// Sequencer model: drives triggers, busy and result writes into the monitor.
// Assumes the bench calls its tasks from one process, all timed on mclk.
`timescale 1ns/1ns

module adcwm_seq_model
(
    // Clock
    input wire logic mclk,
    // Sequencer outputs
    output logic conv_trigger,
    output logic conv_busy,
    output logic result_write,
    output logic [15:0] result_data,
    output logic [4:0] result_channel
);
    logic w_q;
    logic [15:0] d_q;
    logic [4:0] c_q;

    // ==========================================================
    // Idle state at time zero
    initial
    begin
        conv_trigger = 1'b0;
        conv_busy = 1'b0;
        result_write = 1'b0;
        result_data = 16'h5A5A;
        result_channel = 5'h0A;
        w_q = 1'b0;
    end

    // Result strobe; data flips when idle so a stale value never looks valid
    always @(posedge mclk)
    begin
        result_write <= w_q;
        result_data <= w_q ? d_q : ~result_data;
        result_channel <= w_q ? c_q : ~result_channel;
    end

    // ==========================================================
    // Busy for one cycle more than the chosen count, then one result pulse
    task automatic convert(input logic [4:0] ch, input logic [15:0] d, input int cyc);
        @(posedge mclk);
        conv_busy <= 1'b1;
        repeat (cyc) @(posedge mclk);
        w_q <= 1'b1;
        d_q <= d;
        c_q <= ch;
        @(posedge mclk);
        w_q <= 1'b0;
        conv_busy <= 1'b0;
    endtask : convert

    // One trigger, with or without a conversion under way
    task automatic trigger(input logic busy);
        @(posedge mclk);
        conv_busy <= busy;
        conv_trigger <= 1'b1;
        @(posedge mclk);
        conv_trigger <= 1'b0;
        conv_busy <= 1'b0;
    endtask : trigger
endmodule : adcwm_seq_model

// file: testbench/tb_adc_window_compare_monitor.sv
// Self-checking bench of the window monitor over its register bus.
// Assumes the sequencer model file is compiled before this one.
`timescale 1ns/1ns
`include "adcwm_defines.svh"

module tb_adc_window_compare_monitor
    import adcwm_pkg::*;
;
    logic mclk, rst_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, conversion_resolution, rr;
    logic conv_trigger, conv_busy, result_write, result_data_format, irq;
    logic [15:0] result_data;
    logic [4:0] result_channel;
    logic [15:0] wv [5] = '{16'h00FF, 16'h0100, 16'h0200, 16'h0201, 16'h0150};
    logic [3:0] wf [5] = '{4'h2, 4'h8, 4'h8, 4'h4, 4'h8};
    int err_total = 0;
    int checks = 0;

    // ==========================================================
    // Design and sequencer
    adcwm_monitor adcwm_monitor_i (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .conv_trigger(conv_trigger), .conv_busy(conv_busy), .result_write(result_write),
        .result_data(result_data), .result_channel(result_channel),
        .result_data_format(result_data_format),
        .conversion_resolution(conversion_resolution), .irq(irq));
    adcwm_seq_model adcwm_seq_model_i (.mclk(mclk), .conv_trigger(conv_trigger),
        .conv_busy(conv_busy), .result_write(result_write), .result_data(result_data),
        .result_channel(result_channel));

    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Verdict and comparison
    task automatic test_done;
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write: both channels offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid === 1'b1));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, rr);
    endtask : wr

    // Read, then compare data and response
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid === 1'b1));
        rv = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(rv, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rc

    // Irq is a registered level, so let two edges pass first
    task automatic ic(input logic e);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : ic

    // Hang guard well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        test_done;
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rc(8'(i * 4), (i == 3) ? 32'h0000_FFFF : 32'h0, `ADCWM_RESP_OKAY);
        axw(8'h20, 32'h1, rr);
        chk({30'h0, rr}, {30'h0, `ADCWM_RESP_SLVERR});
        rc(8'h20, 32'h0, `ADCWM_RESP_SLVERR);
        wr(`ADCWM_OFS_WLOW, 32'h0100);
        wr(`ADCWM_OFS_WHIGH, 32'h0200);
        wr(`ADCWM_OFS_CHEN, 32'h9);
        // Edges of the window on two channels sharing one threshold pair
        for (int i = 0; i < 5; i++)
        begin
            adcwm_seq_model_i.convert(i[0] ? 5'd3 : 5'd0, wv[i], 2);
            rc(`ADCWM_OFS_STATUS, {28'h0, wf[i]}, `ADCWM_RESP_OKAY);
            rc(`ADCWM_OFS_LAST, {16'h0, wv[i]}, `ADCWM_RESP_OKAY);
            wr(`ADCWM_OFS_CLEAR, 32'hF);
        end
        adcwm_seq_model_i.convert(5'd5, 16'h0010, 1);
        rc(`ADCWM_OFS_STATUS, 32'h0, `ADCWM_RESP_OKAY);
        rc(`ADCWM_OFS_LAST, 32'h0150, `ADCWM_RESP_OKAY);
        // Trigger overflow, stickiness and masking of the interrupt
        adcwm_seq_model_i.trigger(1'b0);
        rc(`ADCWM_OFS_STATUS, 32'h0, `ADCWM_RESP_OKAY);
        adcwm_seq_model_i.trigger(1'b1);
        wr(`ADCWM_OFS_STATUS, 32'h0);
        rc(`ADCWM_OFS_STATUS, 32'h1, `ADCWM_RESP_OKAY);
        ic(1'b0);
        wr(`ADCWM_OFS_IRQEN, 32'h1);
        ic(1'b1);
        wr(`ADCWM_OFS_CLEAR, 32'h1);
        ic(1'b0);
        wr(`ADCWM_OFS_IRQEN, 32'h4);
        adcwm_seq_model_i.convert(5'd0, 16'h0001, 6);
        ic(1'b0);
        wr(`ADCWM_OFS_IRQEN, 32'h2);
        ic(1'b1);
        wr(`ADCWM_OFS_CLEAR, 32'hF);
        // Format change keeps thresholds; software then rewrites them
        wr(`ADCWM_OFS_CTRL, 32'h5);
        chk({31'h0, result_data_format}, 32'h1);
        chk({30'h0, conversion_resolution}, 32'h2);
        rc(`ADCWM_OFS_WLOW, 32'h0100, `ADCWM_RESP_OKAY);
        rc(`ADCWM_OFS_WHIGH, 32'h0200, `ADCWM_RESP_OKAY);
        wr(`ADCWM_OFS_WLOW, 32'hFF00);
        wr(`ADCWM_OFS_WHIGH, 32'h0010);
        adcwm_seq_model_i.convert(5'd3, 16'hFFFF, 2);
        rc(`ADCWM_OFS_STATUS, 32'h8, `ADCWM_RESP_OKAY);
        wr(`ADCWM_OFS_CLEAR, 32'hF);
        adcwm_seq_model_i.convert(5'd0, 16'h8000, 2);
        rc(`ADCWM_OFS_STATUS, 32'h2, `ADCWM_RESP_OKAY);
        // Byte strobes: only the low byte of the low threshold is replaced
        s_axi_wstrb <= 4'h1;
        wr(`ADCWM_OFS_WLOW, 32'h0000_12AB);
        s_axi_wstrb <= 4'hF;
        rc(`ADCWM_OFS_WLOW, 32'h0000_FFAB, `ADCWM_RESP_OKAY);
        test_done;
    end
endmodule : tb_adc_window_compare_monitor
